// ---- rtl/exec_pkg.sv ----
// Constants for the rotate, set and halt execution block
package exec_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_INDEX = 8'h04;
    localparam logic [7:0] OFF_INSTR = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0C;
    localparam logic [7:0] OFF_WAKE = 8'h10;
    localparam logic [7:0] OFF_MEM_ADDR = 8'h14;
    localparam logic [7:0] OFF_MEM_DATA = 8'h18;
    // Control fields
    localparam int CTRL_EXT_BIT = 0;
    localparam int CTRL_BANK_LSB = 8;
    // Status fields
    localparam int ST_BUSY = 0;
    localparam int ST_SLEEP = 1;
    localparam int ST_PD = 2;
    localparam int ST_TO_N = 3;
    localparam int ST_NEG = 4;
    localparam int ST_ZERO = 5;
    localparam int ST_CARRY = 6;
    localparam int ST_ACC_LSB = 8;
    localparam int ST_WDT_LSB = 16;
    // Opcodes
    localparam logic [5:0] OP_ROT_NC = 6'h10;
    localparam logic [5:0] OP_ROT_C = 6'h0C;
    localparam logic [6:0] OP_SET = 7'h34;
    localparam logic [15:0] OP_HALT = 16'h0003;
    // Addressing
    localparam logic [7:0] ACCESS_LIMIT = 8'h5F;
    localparam logic [7:0] ALL_ONES = 8'hFF;
    // Reset values
    localparam logic RST_PD = 1'b1;
    localparam logic RST_TO_N = 1'b1;
    localparam logic [7:0] RST_WDT = 8'h00;
    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Execution phases
    typedef enum logic [2:0]
    {
        PH_IDLE = 3'b000,
        PH_DECODE = 3'b001,
        PH_READ = 3'b010,
        PH_PROCESS = 3'b011,
        PH_WRITE = 3'b100,
        PH_SLEEP = 3'b101
    } phase_t;
endpackage

// ---- rtl/rotate_set_sleep_exec.sv ----
// Execution core for rotate, set-all-ones and halt with an AXI4-Lite register port
// Function
// - Rotate right without carry moves bit zero to bit seven; through carry it moves carry to bit seven and bit zero to carry
// - Destination bit zero writes the accumulator
// - Destination bit one writes the file register
// - Bank bit picks access bank or bank register
// - Extended mode indexes addresses up to 5Fh
// - Set writes FFh, flags unchanged, obeys bank
// - Halt clears the power-down flag
// - Halt sets the active-low expiry flag
// - Halt clears the watchdog counter
// - Halt stops execution until wake-up
module rotate_set_sleep_exec #(
    parameter int BANK_W = 4
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic [2:0] awprot,
    // Write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // Write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // Read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    input wire logic [2:0] arprot,
    // Read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // Core state
    output logic osc_run
);
    localparam int AW = BANK_W + 8;

    logic [7:0] file_mem [0:(2**AW)-1];
    exec_pkg::phase_t phase;
    logic ext_mode;
    logic [BANK_W-1:0] bank_select_register;
    logic [AW-1:0] index_base;
    logic [15:0] opcode;
    logic [AW-1:0] op_addr;
    logic [7:0] operand;
    logic [7:0] result;
    logic [7:0] accumulator;
    logic flag_n;
    logic flag_z;
    logic flag_c;
    logic power_down_flag;
    logic expiry_flag_n;
    logic [7:0] watchdog_counter;
    logic [AW-1:0] mem_addr;
    logic wr_fire;
    logic rd_fire;
    logic is_rot_nc;
    logic is_rot_c;
    logic is_set;
    logic is_halt;
    logic wr_instr;
    logic wr_mem;

    // Effective file address from bank bit and 8-bit field
    function automatic logic [AW-1:0] eff_addr(input logic a, input logic [7:0] f, input logic ext,
        input logic [BANK_W-1:0] bank, input logic [AW-1:0] base);
        if (a)
            return {bank, f};
        else if (ext && f <= exec_pkg::ACCESS_LIMIT)
            return base + AW'(f);
        else if (f <= exec_pkg::ACCESS_LIMIT)
            return {{BANK_W{1'b0}}, f};
        else
            return {{BANK_W{1'b1}}, f};
    endfunction

    // Byte-lane merge of a write
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val, input logic [3:0] strb);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++)
            if (strb[i])
                m[i*8 +: 8] = val[i*8 +: 8];
        return m;
    endfunction

    assign wr_fire = awvalid && awready && wvalid && wready;
    assign rd_fire = arvalid && arready;
    assign is_rot_nc = opcode[15:10] == exec_pkg::OP_ROT_NC;
    assign is_rot_c = opcode[15:10] == exec_pkg::OP_ROT_C;
    assign is_set = opcode[15:9] == exec_pkg::OP_SET;
    assign is_halt = opcode == exec_pkg::OP_HALT;
    assign wr_instr = wr_fire && awaddr == exec_pkg::OFF_INSTR && phase == exec_pkg::PH_IDLE;
    assign wr_mem = wr_fire && awaddr == exec_pkg::OFF_MEM_DATA && phase == exec_pkg::PH_IDLE && wstrb[0];

    // Write channel: take address and data together
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= exec_pkg::RESP_OKAY;
        end
        else
        begin
            awready <= awvalid && wvalid && !awready && !bvalid;
            wready <= awvalid && wvalid && !awready && !bvalid;
            if (wr_fire)
            begin
                bvalid <= 1'b1;
                bresp <= (awaddr[1:0] == 2'b00 && awaddr <= exec_pkg::OFF_MEM_DATA) ?
                    exec_pkg::RESP_OKAY : exec_pkg::RESP_SLVERR;
            end
            else if (bready)
                bvalid <= 1'b0;
        end
    end

    // Read channel
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= exec_pkg::RESP_OKAY;
        end
        else
        begin
            arready <= arvalid && !arready && !rvalid;
            if (rd_fire)
            begin
                rvalid <= 1'b1;
                rresp <= exec_pkg::RESP_OKAY;
                rdata <= 32'h00000000;
                case (araddr)
                    exec_pkg::OFF_CTRL:
                        rdata <= 32'(ext_mode) | (32'(bank_select_register) << exec_pkg::CTRL_BANK_LSB);
                    exec_pkg::OFF_INDEX:
                        rdata <= 32'(index_base);
                    exec_pkg::OFF_INSTR:
                        rdata <= 32'(opcode);
                    exec_pkg::OFF_STATUS:
                        rdata <= 32'(phase != exec_pkg::PH_IDLE && phase != exec_pkg::PH_SLEEP)
                            | (32'(phase == exec_pkg::PH_SLEEP) << exec_pkg::ST_SLEEP)
                            | (32'(power_down_flag) << exec_pkg::ST_PD)
                            | (32'(expiry_flag_n) << exec_pkg::ST_TO_N)
                            | (32'(flag_n) << exec_pkg::ST_NEG)
                            | (32'(flag_z) << exec_pkg::ST_ZERO)
                            | (32'(flag_c) << exec_pkg::ST_CARRY)
                            | (32'(accumulator) << exec_pkg::ST_ACC_LSB)
                            | (32'(watchdog_counter) << exec_pkg::ST_WDT_LSB);
                    exec_pkg::OFF_WAKE:
                        rdata <= 32'h00000000;
                    exec_pkg::OFF_MEM_ADDR:
                        rdata <= 32'(mem_addr);
                    exec_pkg::OFF_MEM_DATA:
                        rdata <= 32'(file_mem[mem_addr]);
                    default:
                        rresp <= exec_pkg::RESP_SLVERR;
                endcase
            end
            else if (rready)
                rvalid <= 1'b0;
        end
    end

    // Software-written configuration
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ext_mode <= 1'b0;
            bank_select_register <= '0;
            index_base <= '0;
            mem_addr <= '0;
        end
        else if (wr_fire)
        begin
            case (awaddr)
                exec_pkg::OFF_CTRL:
                begin
                    ext_mode <= wstrb[0] ? wdata[exec_pkg::CTRL_EXT_BIT] : ext_mode;
                    bank_select_register <= wstrb[1] ? wdata[exec_pkg::CTRL_BANK_LSB +: BANK_W]
                        : bank_select_register;
                end
                exec_pkg::OFF_INDEX:
                    index_base <= AW'(merge(32'(index_base), wdata, wstrb));
                exec_pkg::OFF_MEM_ADDR:
                    mem_addr <= AW'(merge(32'(mem_addr), wdata, wstrb));
                default:
                    mem_addr <= mem_addr;
            endcase
        end
    end

    // Instruction phase sequencer
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            phase <= exec_pkg::PH_IDLE;
            opcode <= 16'h0000;
        end
        else
        begin
            case (phase)
                exec_pkg::PH_IDLE:
                    if (wr_instr)
                    begin
                        opcode <= 16'(merge(32'(opcode), wdata, wstrb));
                        phase <= exec_pkg::PH_DECODE;
                    end
                exec_pkg::PH_DECODE:
                    phase <= exec_pkg::PH_READ;
                exec_pkg::PH_READ:
                    phase <= exec_pkg::PH_PROCESS;
                exec_pkg::PH_PROCESS:
                    phase <= exec_pkg::PH_WRITE;
                exec_pkg::PH_WRITE:
                    phase <= is_halt ? exec_pkg::PH_SLEEP : exec_pkg::PH_IDLE;
                exec_pkg::PH_SLEEP:
                    if (wr_fire && awaddr == exec_pkg::OFF_WAKE && wstrb[0] && wdata[0])
                    begin
                        phase <= exec_pkg::PH_IDLE;
                    end
                default:
                    phase <= exec_pkg::PH_IDLE;
            endcase
        end
    end

    // Operand address, read and processing
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            op_addr <= '0;
            operand <= 8'h00;
            result <= 8'h00;
        end
        else
        begin
            if (phase == exec_pkg::PH_DECODE)
                op_addr <= eff_addr(opcode[8], opcode[7:0], ext_mode, bank_select_register, index_base);
            if (phase == exec_pkg::PH_READ)
                operand <= file_mem[op_addr];
            if (phase == exec_pkg::PH_PROCESS)
            begin
                if (is_set)
                    result <= exec_pkg::ALL_ONES;
                else if (is_rot_c)
                    result <= {flag_c, operand[7:1]};
                else
                    result <= {operand[0], operand[7:1]};
            end
        end
    end

    // File memory: destination write or software access
    always_ff @(posedge aclk)
    begin
        if (phase == exec_pkg::PH_WRITE && (is_set || ((is_rot_nc || is_rot_c) && opcode[9])))
        begin
            file_mem[op_addr] <= result;
        end
        else if (wr_mem)
        begin
            file_mem[mem_addr] <= wdata[7:0];
        end
    end

    // Accumulator and arithmetic flags
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            accumulator <= 8'h00;
            flag_n <= 1'b0;
            flag_z <= 1'b0;
            flag_c <= 1'b0;
        end
        else if (phase == exec_pkg::PH_WRITE && (is_rot_nc || is_rot_c))
        begin
            if (!opcode[9])
            begin
                accumulator <= result;
            end
            flag_n <= result[7];
            flag_z <= result == 8'h00;
            if (is_rot_c)
            begin
                flag_c <= operand[0];
            end
        end
    end

    // Halt side effects and watchdog count
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            power_down_flag <= exec_pkg::RST_PD;
            expiry_flag_n <= exec_pkg::RST_TO_N;
            watchdog_counter <= exec_pkg::RST_WDT;
            osc_run <= 1'b1;
        end
        else if (phase == exec_pkg::PH_WRITE && is_halt)
        begin
            power_down_flag <= 1'b0;
            expiry_flag_n <= 1'b1;
            watchdog_counter <= exec_pkg::RST_WDT;
            osc_run <= 1'b0;
        end
        else if (phase == exec_pkg::PH_SLEEP)
            osc_run <= !(wr_fire && awaddr == exec_pkg::OFF_WAKE && wstrb[0] && wdata[0]) ? 1'b0 : 1'b1;
        else
            watchdog_counter <= watchdog_counter + 8'h01;
    end
endmodule

// ---- bench/exec_props.sv ----
// Port-level assertions for the rotate, set and halt core
module exec_props #(
    parameter int BANK_W = 4
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Write channels
    input wire logic awvalid,
    input wire logic awready,
    input wire logic [7:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [1:0] bresp,
    // Read channels
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [7:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    // Core state
    input wire logic osc_run
);
    timeunit 1ns;
    timeprecision 100ps;
    logic wake_hs;
    logic st_rd;
    assign wake_hs = awready && awaddr == exec_pkg::OFF_WAKE && wstrb[0] && wdata[0];
    assign st_rd = arready && araddr == exec_pkg::OFF_STATUS && !osc_run;
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    a_halt_stops: assert property (
        osc_run && awready && awaddr == exec_pkg::OFF_INSTR && wdata[15:0] == exec_pkg::OP_HALT
        |-> ##[1:8] !osc_run) else $error("halt did not stop the core");
    a_halt_holds: assert property (
        $rose(osc_run) && $past(aresetn) |-> wake_hs || $past(wake_hs) || $past(wake_hs, 2) || $past(wake_hs, 3))
        else $error("core resumed without wake");
    a_pd_cleared: assert property (
        st_rd |=> rdata[exec_pkg::ST_PD] == 1'b0) else $error("power-down flag set while halted");
    a_expiry_set: assert property (
        st_rd |=> rdata[exec_pkg::ST_TO_N] == 1'b1) else $error("expiry flag low while halted");
    a_wdt_cleared: assert property (
        st_rd |=> rdata[23:16] == 8'h00) else $error("watchdog not cleared by halt");
    a_wr_answer: assert property (
        awready |-> wready ##1 bvalid) else $error("write answer out of step");
    a_rd_answer: assert property (
        arready |=> rvalid) else $error("read answer late");
    a_b_holds: assert property (
        bvalid && !bready |=> bvalid && $stable(bresp)) else $error("write response dropped");
    a_r_holds: assert property (
        rvalid && !rready |=> rvalid && $stable(rdata)) else $error("read data dropped");
endmodule

bind rotate_set_sleep_exec exec_props #(.BANK_W(BANK_W)) u_props (.aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(awprot), .wvalid(wvalid),
    .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(arprot), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .rresp(rresp), .osc_run(osc_run));

// ---- bench/test_rotate_set_sleep_exec.sv ----
// Self-checking bench for the rotate, set and halt core
module test_rotate_set_sleep_exec;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed
    {
        logic [15:0] op;
        logic [15:0] ctrl;
        logic [11:0] idx;
        logic [11:0] addr;
        logic [7:0] init;
        logic [7:0] mem;
        logic [7:0] acc;
        logic [1:0] zn;
    } row_t;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hF;
    logic awready, wready, bvalid, arready, rvalid, osc_run;
    logic [1:0] bresp, rresp, rs;
    logic [31:0] rdata, rd;
    int error_cnt = 0;
    int num_checks = 0;
    int n;
    int late = 0;
    logic [7:0] wd;
    row_t rows [9] = '{
        '{16'h4220, 16'h0000, 12'h000, 12'h020, 8'hD7, 8'hEB, 8'h00, 2'b01},
        '{16'h4020, 16'h0000, 12'h000, 12'h020, 8'hD7, 8'hD7, 8'hEB, 2'b01},
        '{16'h4333, 16'h0500, 12'h000, 12'h533, 8'h01, 8'h80, 8'hEB, 2'b01},
        '{16'h6912, 16'h0500, 12'h000, 12'h512, 8'h5A, 8'hFF, 8'hEB, 2'b01},
        '{16'h425F, 16'h0001, 12'h300, 12'h35F, 8'h02, 8'h01, 8'hEB, 2'b00},
        '{16'h4260, 16'h0001, 12'h300, 12'hF60, 8'h80, 8'h40, 8'hEB, 2'b00},
        '{16'h4240, 16'h0000, 12'h000, 12'h040, 8'h00, 8'h00, 8'hEB, 2'b10},
        '{16'h6810, 16'h0001, 12'h300, 12'h310, 8'h5A, 8'hFF, 8'hEB, 2'b10},
        '{16'h3220, 16'h0000, 12'h000, 12'h020, 8'hD7, 8'h6B, 8'hEB, 2'b00}};

    rotate_set_sleep_exec #(.BANK_W(4)) dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
        .awready(awready), .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready),
        .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid),
        .rready(rready), .rdata(rdata), .rresp(rresp), .osc_run(osc_run));

    always #2.5 aclk = ~aclk;

    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        awaddr <= a;
        wdata <= d;
        bready <= late == 0;
        n = 0;
        do
        begin
            @(posedge aclk);
            n++;
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            if (n == late) bready <= 1'b1;
        end
        while (!(bvalid === 1'b1 && bready === 1'b1) && n < 100);
        rs = bresp;
        bready <= 1'b0;
    endtask

    task rdr(input logic [7:0] a);
        @(posedge aclk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= late == 0;
        n = 0;
        do
        begin
            @(posedge aclk);
            n++;
            if (arready === 1'b1) arvalid <= 1'b0;
            if (n == late) rready <= 1'b1;
        end
        while (!(rvalid === 1'b1 && rready === 1'b1) && n < 100);
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask

    task wait_idle;
        repeat (20)
        begin
            rdr(exec_pkg::OFF_STATUS);
            if (rd[exec_pkg::ST_BUSY] === 1'b0) break;
        end
    endtask

    task wait_run(input logic v);
        n = 0;
        while (osc_run !== v && n < 20)
        begin
            @(posedge aclk);
            n++;
        end
    endtask

    task complete_run;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge aclk);
        error_cnt++;
        complete_run();
    end

    initial
    begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rdr(exec_pkg::OFF_STATUS);
        chk("reset status", 32'h0000_000C, rd & 32'h0000_FFFF);
        foreach (rows[i])
        begin
            wr(exec_pkg::OFF_CTRL, {16'h0, rows[i].ctrl});
            wr(exec_pkg::OFF_INDEX, {20'h0, rows[i].idx});
            wr(exec_pkg::OFF_MEM_ADDR, {20'h0, rows[i].addr});
            wr(exec_pkg::OFF_MEM_DATA, {24'h0, rows[i].init});
            wr(exec_pkg::OFF_INSTR, {16'h0, rows[i].op});
            wait_idle();
            chk("zero and negative", {30'h0, rows[i].zn}, {30'h0, rd[5:4]});
            chk("accumulator", {24'h0, rows[i].acc}, {24'h0, rd[15:8]});
            rdr(exec_pkg::OFF_MEM_DATA);
            chk("file byte", {24'h0, rows[i].mem}, {24'h0, rd[7:0]});
        end
        wr(exec_pkg::OFF_INSTR, 32'h0000_4220);
        wait_idle();
        chk("carry kept", 32'h1, {31'h0, rd[exec_pkg::ST_CARRY]});
        late = 4;
        wr(exec_pkg::OFF_INDEX, 32'h0000_0123);
        rdr(exec_pkg::OFF_INDEX);
        late = 0;
        chk("late response", 32'h0000_0123, rd);
        wr(8'h1C, 32'h0);
        chk("unmapped write", {30'h0, exec_pkg::RESP_SLVERR}, {30'h0, rs});
        rdr(8'h1C);
        chk("unmapped read", {30'h0, exec_pkg::RESP_SLVERR}, {30'h0, rs});
        wr(exec_pkg::OFF_INSTR, 32'h0000_0004);
        wait_idle();
        chk("run after other opcode", 32'h1, {31'h0, osc_run});
        wd = rd[23:16];
        rdr(exec_pkg::OFF_STATUS);
        chk("watchdog counting", 32'h1, {31'h0, rd[23:16] != wd});
        wr(exec_pkg::OFF_INSTR, {16'h0, exec_pkg::OP_HALT});
        wait_run(1'b0);
        chk("halted oscillator", 32'h0, {31'h0, osc_run});
        rdr(exec_pkg::OFF_STATUS);
        chk("halt status", 32'h0000_000A, rd & 32'h00FF_000E);
        wr(exec_pkg::OFF_INSTR, 32'h0000_4010);
        rdr(exec_pkg::OFF_STATUS);
        rdr(exec_pkg::OFF_STATUS);
        chk("accumulator while halted", 32'hEB, {24'h0, rd[15:8]});
        wr(exec_pkg::OFF_WAKE, 32'h1);
        wait_run(1'b1);
        chk("woken oscillator", 32'h1, {31'h0, osc_run});
        wr(exec_pkg::OFF_INSTR, {16'h0, exec_pkg::OP_HALT});
        wait_run(1'b0);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rdr(exec_pkg::OFF_STATUS);
        chk("run after reset", 32'h1, {31'h0, osc_run});
        chk("status after reset", 32'h0000_000C, rd & 32'h0000_FFFF);
        complete_run();
    end
endmodule
